/* fss_pkg.sv */
// fss_pkg: offsets, field positions, reset values and load constants
// for the fault select / status register slice.
// assumes: byte-wide register port from the serial bus engine.
package fss_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CSOPT_B = 8'h17;
    localparam logic [7:0] OFS_CLAMP   = 8'h18;
    localparam logic [7:0] OFS_SETPT   = 8'h19;
    localparam logic [7:0] OFS_SEL_A   = 8'h1A;
    localparam logic [7:0] OFS_SEL_B   = 8'h1B;
    localparam logic [7:0] OFS_MAKER   = 8'h1C;
    localparam logic [7:0] OFS_REV     = 8'h1D;
    localparam logic [7:0] OFS_STAT_A  = 8'h2A;

    // ------------------------------------------------------------
    // nonvolatile copies and power-up load
    // ------------------------------------------------------------
    localparam logic [15:0] NV_BASE    = 16'h8117;
    localparam int          CFG_COUNT  = 5;
    localparam logic [2:0]  CFG_LAST   = 3'h4;
    localparam logic [2:0]  IDX_CLAMP  = 3'h1;
    localparam logic [2:0]  IDX_SETPT  = 3'h2;
    localparam logic [2:0]  IDX_SEL_A  = 3'h3;
    localparam logic [2:0]  IDX_SEL_B  = 3'h4;

    // ------------------------------------------------------------
    // identity values (arbitrary, not any real part)
    // ------------------------------------------------------------
    localparam logic [7:0] MAKER_ID    = 8'h5A;
    localparam logic [3:0] REV_MAJOR   = 4'h2;
    localparam logic [3:0] REV_MINOR   = 4'h3;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int         SELB_SUPPLY = 7;
    localparam int         SELB_HOST   = 2;
    localparam logic [7:0] HOST_MASK   = 8'h04;
    localparam logic [7:0] STAT_RESET  = 8'h00;
    localparam logic [7:0] DATA_ZERO   = 8'h00;

endpackage : fss_pkg

/* fss_status_latch.sv */
// fss_status_latch: eight edge-set, read-cleared fault flags.
// assumes: sources synchronous to clock; rd_clr is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none

module fss_status_latch (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rstn,
    input  wire logic       ce,
    // sources and clear
    input  wire logic [7:0] src,
    input  wire logic       rd_clr,
    // flags
    output logic      [7:0] flags
);

    logic [7:0] prev_r;
    logic [7:0] prev_nxt;
    logic [7:0] flag_r;
    logic [7:0] flag_nxt;
    logic [7:0] rise;

    // ------------------------------------------------------------
    // per-bit next state
    // ------------------------------------------------------------
    assign rise = src & ~prev_r;

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_bit
            always_comb begin
                prev_nxt[g] = src[g];
                // set wins over a clear in the same cycle
                if (rd_clr) begin
                    flag_nxt[g] = (flag_r[g] & src[g]) | rise[g];
                end else begin
                    flag_nxt[g] = flag_r[g] | rise[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            prev_r <= fss_pkg::STAT_RESET;
            flag_r <= fss_pkg::STAT_RESET;
        end else if (ce) begin
            prev_r <= prev_nxt;
            flag_r <= flag_nxt;
        end
    end

    assign flags = flag_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    a_rise_sets: assert property (ce && rise != 8'h00
        |=> (flag_r & $past(rise)) == $past(rise))
        else $error("rising source did not set its flag");
    a_held_quiet: assert property (ce && rise == 8'h00 && flag_r == 8'h00
        |=> flag_r == 8'h00)
        else $error("flag set without a rising source");
    a_read_clears: assert property (ce && rd_clr |=> (flag_r & ~$past(src)) == 8'h00
        && (flag_r & $past(flag_r & src)) == $past(flag_r & src))
        else $error("read clear handled a flag wrongly");

endmodule : fss_status_latch

`default_nettype wire

/* fss_regs.sv */
// fss_regs: trims, fault route selects, identity and first status mirror.
// assumes: serial bus engine gives byte reads/writes on a strobe port;
// nonvolatile copies answer a held request with a one-cycle valid.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - at power-up load offsets 17h..1Bh from copies 8117h..811Bh
// - read/write byte at 18h drives the false undervoltage clamp trim
// - read/write byte at 19h drives the output setpoint trim
// - select A at 1Ah routes eight fault sources, one per bit
// - select B at 1Bh routes supply, monitor flags, host control; bit 0 unused
// - read-only maker identification byte at 1Ch, writes ignored
// - read-only revision at 1Dh: generation high nibble, minor revision low
// - status mirror at 2Ah resets to zero, holds latched fault flags
// - a status flag sets only on its source going active
// - reading the mirror clears flags whose fault is gone, keeps others
// - selected host control bit drives the fault indicator directly
module fss_regs (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        ce,
    // register port from the serial bus engine
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    output logic             reg_rvalid,
    output logic             load_busy,
    // nonvolatile copy fetch
    output logic             nv_req,
    output logic      [15:0] nv_addr,
    input  wire logic        nv_valid,
    input  wire logic [7:0]  nv_data,
    // fault sources
    input  wire logic        overvoltage,
    input  wire logic        undervoltage,
    input  wire logic        overcurrent_timeout,
    input  wire logic        mains_sense_bad,
    input  wire logic        overcurrent_flag,
    input  wire logic        overtemperature,
    input  wire logic        oring_switch_bad,
    input  wire logic        share_bad,
    input  wire logic        supply_bad,
    input  wire logic        monitor_flag_1,
    input  wire logic        monitor_flag_2,
    input  wire logic        monitor_flag_3,
    input  wire logic        monitor_flag_4,
    input  wire logic        monitor_flag_5,
    input  wire logic        host_fault_write,
    // trims and fault outputs
    output logic      [7:0]  current_sense_option_b,
    output logic      [7:0]  false_undervoltage_clamp_trim,
    output logic      [7:0]  output_setpoint_trim,
    output logic             fault_indicator,
    output logic             smbus_alert
);

    typedef enum logic {FSS_LOAD, FSS_RUN} fss_state_e;

    function automatic logic fss_is_cfg(input logic [7:0] a);
        return (a >= fss_pkg::OFS_CSOPT_B) && (a <= fss_pkg::OFS_SEL_B);
    endfunction : fss_is_cfg

    function automatic logic fss_hit(input logic [7:0] sel, input logic [7:0] src);
        return |(sel & src);
    endfunction : fss_hit

    fss_state_e  state_r;
    fss_state_e  state_nxt;
    logic [2:0]  idx_r;
    logic [2:0]  idx_nxt;
    logic        req_r;
    logic        req_nxt;
    logic [7:0]  cfg_r   [fss_pkg::CFG_COUNT];
    logic [7:0]  cfg_nxt [fss_pkg::CFG_COUNT];
    logic [7:0]  rdata_r;
    logic [7:0]  rdata_nxt;
    logic        rvalid_r;
    logic        rvalid_nxt;
    logic        fault_r;
    logic        fault_nxt;
    logic        alert_r;
    logic        alert_nxt;
    logic        take_nv;
    logic        run;
    logic [2:0]  acc_idx;
    logic [7:0]  src_a;
    logic [7:0]  src_b;
    logic [7:0]  src_stat;
    logic [7:0]  stat_flags;
    logic        stat_clr;
    logic        hit_a;
    logic        hit_b;
    logic        hit_b_alert;

    // ------------------------------------------------------------
    // power-up load sequencer
    // ------------------------------------------------------------
    // the slow copy store is polled with a held request, one byte at a time
    assign take_nv = req_r && nv_valid;
    assign run     = (state_r == FSS_RUN);

    always_comb begin
        state_nxt = state_r;
        idx_nxt   = idx_r;
        req_nxt   = req_r;
        unique case (state_r)
            FSS_LOAD: begin
                req_nxt = 1'b1;
                if (take_nv) begin
                    if (idx_r == fss_pkg::CFG_LAST) begin
                        state_nxt = FSS_RUN;
                        req_nxt   = 1'b0;
                    end else begin
                        idx_nxt = idx_r + 3'h1;
                    end
                end
            end
            FSS_RUN: begin
                req_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_r <= FSS_LOAD;
            idx_r   <= 3'h0;
            req_r   <= 1'b0;
        end else if (ce) begin
            state_r <= state_nxt;
            idx_r   <= idx_nxt;
            req_r   <= req_nxt;
        end
    end

    // ------------------------------------------------------------
    // configuration bytes
    // ------------------------------------------------------------
    assign acc_idx = 3'(reg_addr - fss_pkg::OFS_CSOPT_B);

    always_comb begin
        for (int i = 0; i < fss_pkg::CFG_COUNT; i++) begin
            cfg_nxt[i] = cfg_r[i];
        end
        if (!run && take_nv) begin
            cfg_nxt[idx_r] = nv_data;
        end else if (run && reg_wr && fss_is_cfg(reg_addr)) begin
            cfg_nxt[acc_idx] = reg_wdata;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // reads refused while loading: values would not yet be the copies
    always_comb begin
        rvalid_nxt = run && reg_rd;
        rdata_nxt  = fss_pkg::DATA_ZERO;
        if (run && reg_rd) begin
            if (fss_is_cfg(reg_addr)) begin
                rdata_nxt = cfg_r[acc_idx];
            end else if (reg_addr == fss_pkg::OFS_MAKER) begin
                rdata_nxt = fss_pkg::MAKER_ID;
            end else if (reg_addr == fss_pkg::OFS_REV) begin
                rdata_nxt = {fss_pkg::REV_MAJOR, fss_pkg::REV_MINOR};
            end else if (reg_addr == fss_pkg::OFS_STAT_A) begin
                rdata_nxt = stat_flags;
            end
        end
    end

    // ------------------------------------------------------------
    // status mirror one
    // ------------------------------------------------------------
    assign src_stat = {overvoltage, undervoltage, overcurrent_timeout, monitor_flag_1,
                       monitor_flag_2, monitor_flag_3, monitor_flag_4, monitor_flag_5};
    assign stat_clr = run && reg_rd && (reg_addr == fss_pkg::OFS_STAT_A);

    fss_status_latch u_stat (
        .clock  (clock),
        .rstn   (rstn),
        .ce     (ce),
        .src    (src_stat),
        .rd_clr (stat_clr),
        .flags  (stat_flags)
    );

    // ------------------------------------------------------------
    // fault routing
    // ------------------------------------------------------------
    assign src_a = {overvoltage, undervoltage, overcurrent_timeout, mains_sense_bad,
                    overcurrent_flag, overtemperature, oring_switch_bad, share_bad};
    assign src_b = {supply_bad, monitor_flag_1, monitor_flag_2, monitor_flag_3,
                    monitor_flag_4, host_fault_write, monitor_flag_5, 1'b0};
    assign hit_a       = fss_hit(cfg_r[fss_pkg::IDX_SEL_A], src_a);
    assign hit_b       = fss_hit(cfg_r[fss_pkg::IDX_SEL_B], src_b);
    // host bit is a direct drive of the indicator, not a fault to alert on
    assign hit_b_alert = fss_hit(cfg_r[fss_pkg::IDX_SEL_B] & ~fss_pkg::HOST_MASK, src_b);

    always_comb begin
        fault_nxt = run && (hit_a || hit_b);
        alert_nxt = run && (hit_a || hit_b_alert);
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < fss_pkg::CFG_COUNT; i++) begin
                cfg_r[i] <= fss_pkg::DATA_ZERO;
            end
            rdata_r  <= fss_pkg::DATA_ZERO;
            rvalid_r <= 1'b0;
            fault_r  <= 1'b0;
            alert_r  <= 1'b0;
        end else if (ce) begin
            for (int i = 0; i < fss_pkg::CFG_COUNT; i++) begin
                cfg_r[i] <= cfg_nxt[i];
            end
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            fault_r  <= fault_nxt;
            alert_r  <= alert_nxt;
        end
    end

    assign reg_rdata                     = rdata_r;
    assign reg_rvalid                    = rvalid_r;
    assign load_busy                     = !run;
    assign nv_req                        = req_r;
    assign nv_addr                       = fss_pkg::NV_BASE + {13'h0000, idx_r};
    assign current_sense_option_b        = cfg_r[0];
    assign false_undervoltage_clamp_trim = cfg_r[fss_pkg::IDX_CLAMP];
    assign output_setpoint_trim          = cfg_r[fss_pkg::IDX_SETPT];
    assign fault_indicator               = fault_r;
    assign smbus_alert                   = alert_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    a_load_ends: assert property (ce && !run && take_nv && idx_r == fss_pkg::CFG_LAST
        |=> run && !req_r)
        else $error("load did not end after last copy");
    a_load_store: assert property (ce && !run && take_nv && idx_r == fss_pkg::IDX_CLAMP
        |=> false_undervoltage_clamp_trim == $past(nv_data))
        else $error("copy byte not stored");
    a_clamp_write: assert property (ce && run && reg_wr
        && reg_addr == fss_pkg::OFS_CLAMP |=> false_undervoltage_clamp_trim == $past(reg_wdata))
        else $error("clamp trim write lost");
    a_setpt_write: assert property (ce && run && reg_wr
        && reg_addr == fss_pkg::OFS_SETPT |=> output_setpoint_trim == $past(reg_wdata))
        else $error("setpoint trim write lost");
    a_route_ov: assert property (ce && run && overvoltage
        && cfg_r[fss_pkg::IDX_SEL_A][7] |=> fault_indicator && smbus_alert)
        else $error("selected overvoltage not routed");
    a_route_supply: assert property (ce && run && supply_bad
        && cfg_r[fss_pkg::IDX_SEL_B][fss_pkg::SELB_SUPPLY] |=> fault_indicator)
        else $error("selected supply fault not routed");
    a_maker_read: assert property (ce && run && reg_rd
        && reg_addr == fss_pkg::OFS_MAKER |=> reg_rvalid && reg_rdata == fss_pkg::MAKER_ID)
        else $error("maker id read wrong");
    a_rev_read: assert property (ce && run && reg_rd
        && reg_addr == fss_pkg::OFS_REV |=> reg_rdata == {fss_pkg::REV_MAJOR, fss_pkg::REV_MINOR})
        else $error("revision read wrong");
    a_stat_read: assert property (ce && stat_clr |=> reg_rdata == $past(stat_flags))
        else $error("status read wrong");
    a_host_drive: assert property (ce && run && host_fault_write
        && cfg_r[fss_pkg::IDX_SEL_B][fss_pkg::SELB_HOST] |=> fault_indicator)
        else $error("host drive not on indicator");
    a_quiet_out: assert property (ce && !(hit_a || hit_b)
        |=> !fault_indicator && !smbus_alert)
        else $error("indicator without selected source");

    c_load_done: cover property (take_nv && idx_r == fss_pkg::CFG_LAST);
    c_stat_clear: cover property (stat_clr && stat_flags != 8'h00);
    c_alert: cover property (run && smbus_alert);
    c_host: cover property (fault_indicator && !smbus_alert);

endmodule : fss_regs

`default_nettype wire

/* fss_nv_model.sv */
// fss_nv_model: nonvolatile copy store answering the power-up load.
// assumes: request held until its valid is taken; single clock domain.
`timescale 1ns/1ps
`default_nettype none

module fss_nv_model (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    // copy fetch
    input  wire logic        nv_req,
    input  wire logic [15:0] nv_addr,
    output logic             nv_valid,
    output logic      [7:0]  nv_data
);
    // ------------------------------------------------------------
    // answer logic
    // ------------------------------------------------------------
    // even addresses answer slowly, odd ones at once, to mix both paces
    logic [1:0] cnt_r;
    logic [1:0] dly;

    assign dly = nv_addr[0] ? 2'h0 : 2'h2;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            nv_valid <= 1'h0;
            nv_data  <= 8'hFF;
            cnt_r    <= 2'h0;
        end else begin
            nv_valid <= 1'h0;
            // idle data toggles so a stale copy is never mistaken for data
            nv_data  <= ~nv_data;
            if (nv_req && !nv_valid) begin
                if (cnt_r == dly) begin
                    nv_valid <= 1'h1;
                    nv_data  <= {4'hC, nv_addr[3:0]};
                    cnt_r    <= 2'h0;
                end else begin
                    cnt_r <= cnt_r + 2'h1;
                end
            end
        end
    end
endmodule : fss_nv_model

`default_nettype wire

/* fault_select_status_registers_bench.sv */
// fault_select_status_registers_bench: directed checks of the register slice.
// assumes: fss_regs and fss_nv_model compiled first; ce held high except for the frozen write in t_reset.
`timescale 1ns/1ps
`default_nettype none

module fault_select_status_registers_bench;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        clock, rstn, ce, reg_wr, reg_rd, reg_rvalid, load_busy;
    logic        nv_req, nv_valid, fault_indicator, smbus_alert;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, nv_data, src_a, src_b;
    logic [7:0]  csopt, clamp, setpt;
    logic [15:0] nv_addr;
    int          n_errors, compares;

    fss_regs dut (.clock(clock), .rstn(rstn), .ce(ce), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .load_busy(load_busy), .nv_req(nv_req),
        .nv_addr(nv_addr), .nv_valid(nv_valid), .nv_data(nv_data),
        .overvoltage(src_a[7]), .undervoltage(src_a[6]), .overcurrent_timeout(src_a[5]),
        .mains_sense_bad(src_a[4]), .overcurrent_flag(src_a[3]),
        .overtemperature(src_a[2]), .oring_switch_bad(src_a[1]), .share_bad(src_a[0]),
        .supply_bad(src_b[7]), .monitor_flag_1(src_b[6]), .monitor_flag_2(src_b[5]),
        .monitor_flag_3(src_b[4]), .monitor_flag_4(src_b[3]), .monitor_flag_5(src_b[1]),
        .host_fault_write(src_b[2]), .current_sense_option_b(csopt),
        .false_undervoltage_clamp_trim(clamp), .output_setpoint_trim(setpt),
        .fault_indicator(fault_indicator), .smbus_alert(smbus_alert));

    fss_nv_model nv (.clock(clock), .rstn(rstn), .nv_req(nv_req), .nv_addr(nv_addr),
        .nv_valid(nv_valid), .nv_data(nv_data));

    // ------------------------------------------------------------
    // clock, reset values and watchdog
    // ------------------------------------------------------------
    initial begin
        clock = 1'h0;
        forever #10 clock = ~clock;
    end

    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        tally_and_finish();
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        if (n_errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'h1;
        @(posedge clock);
        reg_wr    <= 1'h0;
        #1;
    endtask : wr

    // answer is looked at in the one cycle that it stands
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'h1;
        @(posedge clock);
        reg_rd   <= 1'h0;
        #1;
        chk("rvalid", 8'h01, {7'h00, reg_rvalid});
        chk("rdata", exp, reg_rdata);
    endtask : rd

    // sources change at an edge; outputs follow one cycle later
    task automatic route(input logic [7:0] a, input logic [7:0] b, input logic [1:0] exp);
        @(posedge clock);
        src_a <= a;
        src_b <= b;
        @(posedge clock);
        #1;
        chk("indicator_alert", {6'h00, exp}, {6'h00, fault_indicator, smbus_alert});
    endtask : route

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_load();
        @(posedge clock);
        reg_addr <= 8'h1A;
        reg_rd   <= 1'h1;
        @(posedge clock);
        reg_rd   <= 1'h0;
        #1;
        chk("rvalid_busy", 8'h00, {7'h00, reg_rvalid});
        for (int i = 0; i < 100 && load_busy !== 1'h0; i++) @(posedge clock);
        chk("load_busy", 8'h00, {7'h00, load_busy});
        chk("csopt", 8'hC7, csopt);
        chk("clamp", 8'hC8, clamp);
        chk("setpt", 8'hC9, setpt);
        rd(8'h1A, 8'hCA);
        rd(8'h1B, 8'hCB);
        rd(8'h2A, fss_pkg::STAT_RESET);
    endtask : t_load

    task automatic t_regs();
        wr(8'h18, 8'hA5);
        wr(8'h19, 8'h5A);
        chk("clamp_wr", 8'hA5, clamp);
        chk("setpt_wr", 8'h5A, setpt);
        rd(8'h18, 8'hA5);
        rd(8'h19, 8'h5A);
        wr(8'h1C, 8'h33);
        wr(8'h1D, 8'h33);
        rd(8'h1C, fss_pkg::MAKER_ID);
        rd(8'h1D, {fss_pkg::REV_MAJOR, fss_pkg::REV_MINOR});
        rd(8'h30, 8'h00);
    endtask : t_regs

    // one-cycle pulse on each mirrored source, then read twice
    task automatic t_status();
        logic [7:0] a, b;
        for (int k = 0; k < 8; k++) begin
            a = 8'h00;
            b = 8'h00;
            if (k >= 5) a[k] = 1'h1;
            else if (k >= 1) b[k + 2] = 1'h1;
            else b[1] = 1'h1;
            @(posedge clock);
            src_a <= a;
            src_b <= b;
            @(posedge clock);
            src_a <= 8'h00;
            src_b <= 8'h00;
            rd(8'h2A, 8'h01 << k);
            rd(8'h2A, 8'h00);
        end
        route(8'h80, 8'h40, 2'h3);
        rd(8'h2A, 8'h90);
        route(8'h80, 8'h00, 2'h3);
        rd(8'h2A, 8'h90);
        rd(8'h2A, 8'h80);
        route(8'h00, 8'h00, 2'h0);
        rd(8'h2A, 8'h80);
        rd(8'h2A, 8'h00);
    endtask : t_status

    // each select bit alone: its source asserts (host bit: indicator only; unused B bit 0: nothing), all others do not
    task automatic t_route();
        for (int i = 0; i < 8; i++) begin
            wr(8'h1A, 8'h01 << i);
            wr(8'h1B, 8'h00);
            route(8'h01 << i, 8'h00, 2'h3);
            route(~(8'h01 << i), 8'hFF, 2'h0);
        end
        for (int i = 0; i < 8; i++) begin
            wr(8'h1A, 8'h00);
            wr(8'h1B, 8'h01 << i);
            if (i == 0) route(8'hFF, 8'hFF, 2'h0);
            else if (i == 2) route(8'h00, 8'h04, 2'h2);
            else route(8'h00, 8'h01 << i, 2'h3);
            route(8'hFF, ~(8'h01 << i), 2'h0);
        end
        route(8'h00, 8'h00, 2'h0);
    endtask : t_route

    // mid-run reset reloads the copies; a low enable freezes a write
    task automatic t_reset();
        @(posedge clock);
        rstn <= 1'h0;
        @(posedge clock);
        #1;
        chk("busy_rst", 8'h01, {7'h00, load_busy});
        chk("req_rst", 8'h00, {7'h00, nv_req});
        chk("nvaddr_hi", 8'h81, nv_addr[15:8]);
        chk("nvaddr_lo", 8'h17, nv_addr[7:0]);
        chk("clamp_rst", 8'h00, clamp);
        chk("ind_rst", 8'h00, {6'h00, fault_indicator, smbus_alert});
        @(posedge clock);
        rstn <= 1'h1;
        @(posedge clock);
        #1;
        chk("req_on", 8'h01, {7'h00, nv_req});
        for (int i = 0; i < 100 && load_busy !== 1'h0; i++) @(posedge clock);
        #1;
        chk("req_off", 8'h00, {7'h00, nv_req});
        chk("clamp_reload", 8'hC8, clamp);
        rd(8'h2A, fss_pkg::STAT_RESET);
        @(posedge clock);
        ce <= 1'h0;
        wr(8'h18, 8'h3C);
        chk("clamp_frozen", 8'hC8, clamp);
        @(posedge clock);
        ce <= 1'h1;
    endtask : t_reset

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rstn      = 1'h0;
        reg_wr    = 1'h0;
        reg_rd    = 1'h0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        src_a     = 8'h00;
        src_b     = 8'h00;
        ce        = 1'h1;
        n_errors  = 0;
        compares  = 0;
        repeat (16) @(posedge clock);
        rstn <= 1'h1;
        t_load();
        t_regs();
        t_status();
        t_route();
        t_reset();
        tally_and_finish();
    end
endmodule : fault_select_status_registers_bench

`default_nettype wire
